// file: hw/thsie_consts.vh
// Overview of operation
// RL1: Equivalent variant: both inputs high within 0.5 s.
// RL2: Both channels must be off before actuation; in equivalent mode the reset value of sync_q counts as both off.
// RL3: Equivalent discrepancy time fixed at 500 ms.
// RL4: Complementary pairs: on is high/low, off low/high.
// RL5: Sync fixed 500 ms; pair discrepancy 0-500 ms.
// RL6: Magnetic switch discrepancy default is 1.5 s.
// RL7: Selector: 2-8 modes untested, 2-4 tested.
// RL8: Odd test pulses feed odd inputs only.
// RL9: Test period shorter than sensor switch-off.
// RL10: On timeout, output off and error until released.
`ifndef THSIE_CONSTS_VH
`define THSIE_CONSTS_VH
`define THSIE_CLK_MHZ 125
`define THSIE_SYNC_MS 500
`define THSIE_SYNC_CYC (`THSIE_SYNC_MS * 1000 * `THSIE_CLK_MHZ)
`define THSIE_MAG_DISC_MS 1500
`define THSIE_MAG_DISC_CYC (`THSIE_MAG_DISC_MS * 1000 * `THSIE_CLK_MHZ)
`define THSIE_CYC_PER_MS (1000 * `THSIE_CLK_MHZ)
`define THSIE_CNT_W 28
`define THSIE_DISC_MAX_MS 9'h1f4
`define THSIE_ST_IDLE 2'h0
`define THSIE_ST_WAIT 2'h1
`define THSIE_ST_ON 2'h2
`define THSIE_ST_ERR 2'h3
`define THSIE_MODES_MIN 4'h2
`define THSIE_MODES_MAX_UNTESTED 4'h8
`define THSIE_MODES_MAX_TESTED 4'h4
`endif

// file: hw/thsie_two_hand_eval.v
`timescale 1ns/1ps
`default_nettype none
`include "thsie_consts.vh"
module thsie_two_hand_eval #(
  parameter [27:0] SYNC_CYC = `THSIE_SYNC_CYC,
  parameter [27:0] MAG_DISC_CYC = `THSIE_MAG_DISC_CYC,
  parameter [27:0] CYC_PER_MS = `THSIE_CYC_PER_MS
) (
  input wire mclk,
  input wire sys_rst,
  input wire complementaryMode,
  input wire magneticMode,
  input wire [8:0] pairDiscMs,
  input wire safe_input_one,
  input wire safe_input_two,
  input wire safeInputThree,
  input wire safeInputFour,
  input wire selectorTested,
  input wire [3:0] selectorModes,
  output reg twoHandValid_q,
  output reg evalError_q,
  output reg selectorCfgOk_q
);
  // ==========================================
  // Input synchronisers.
  reg [3:0] meta_q;
  reg [3:0] sync_q;
  always @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {safeInputFour, safeInputThree, safe_input_two, safe_input_one};
      sync_q <= meta_q;
    end
  end

  // ==========================================
  // State codes.
  localparam [1:0] ST_IDLE = `THSIE_ST_IDLE;
  localparam [1:0] ST_WAIT = `THSIE_ST_WAIT;
  localparam [1:0] ST_ON = `THSIE_ST_ON;
  localparam [1:0] ST_ERR = `THSIE_ST_ERR;

  // ==========================================
  // Contact decode functions.
  function handOnDec;
    input comp;
    input noContact;
    input ncContact;
    begin
      handOnDec = comp ? (noContact & ~ncContact) : noContact;
    end
  endfunction

  function handOffDec;
    input comp;
    input noContact;
    input ncContact;
    begin
      handOffDec = comp ? (~noContact & ncContact) : ~noContact;
    end
  endfunction

  // ==========================================
  // Channel decode.
  wire handBNo = complementaryMode ? sync_q[2] : sync_q[1];
  wire handAOn = handOnDec(complementaryMode, sync_q[0], sync_q[1]); // RL4
  wire handBOn = handOnDec(complementaryMode, handBNo, sync_q[3]); // RL4
  wire handAOff = handOffDec(complementaryMode, sync_q[0], sync_q[1]); // RL4
  wire handBOff = handOffDec(complementaryMode, handBNo, sync_q[3]); // RL4
  wire pairAMix = complementaryMode & ~handAOn & ~handAOff;
  wire pairBMix = complementaryMode & ~handBOn & ~handBOff;
  wire [8:0] discMs = (pairDiscMs > `THSIE_DISC_MAX_MS) ? `THSIE_DISC_MAX_MS : pairDiscMs; // RL5
  wire [36:0] pairDiscProd = discMs * CYC_PER_MS; // RL5
  wire [27:0] pairDiscCyc = pairDiscProd[27:0]; // RL5
  wire magEquiv = magneticMode & ~complementaryMode;
  wire [27:0] syncLimit = magEquiv ? MAG_DISC_CYC : SYNC_CYC; // RL3 RL6

  // ==========================================
  // Per-pair discrepancy timers.
  reg [27:0] discCnt_q [0:1];
  wire [1:0] pairMix = {pairBMix, pairAMix};
  wire [1:0] discTimeout;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gDisc
      always @(posedge mclk) begin
        if (sys_rst || !pairMix[g]) begin
          discCnt_q[g] <= 28'h0;
        end else if (discCnt_q[g] <= pairDiscCyc) begin
          discCnt_q[g] <= discCnt_q[g] + 28'h1;
        end
      end
      assign discTimeout[g] = pairMix[g] && (discCnt_q[g] >= pairDiscCyc); // RL5
    end
  endgenerate

  // ==========================================
  // Two-hand evaluation state machine.
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [27:0] syncCnt_q;
  reg [27:0] syncCnt_d;
  reg twoHandValid_d;
  reg evalError_d;
  wire bothOff = handAOff & handBOff;
  wire bothOn = handAOn & handBOn;
  wire syncExpired = (syncCnt_q >= syncLimit - 28'h1); // RL1 RL5

  always @* begin
    state_d = state_q;
    syncCnt_d = syncCnt_q;
    twoHandValid_d = twoHandValid_q;
    evalError_d = evalError_q;
    case (state_q)
      ST_IDLE: begin
        twoHandValid_d = 1'b0;
        syncCnt_d = 28'h0;
        if (|discTimeout) begin
          state_d = ST_ERR; // RL10
          evalError_d = 1'b1;
        end else if (bothOn) begin
          state_d = ST_ON; // RL1
          twoHandValid_d = 1'b1;
        end else if (!bothOff) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        syncCnt_d = syncCnt_q + 28'h1;
        if (|discTimeout || syncExpired) begin
          state_d = ST_ERR; // RL10
          evalError_d = 1'b1;
        end else if (bothOn) begin
          state_d = ST_ON; // RL1
          twoHandValid_d = 1'b1;
        end else if (bothOff) begin
          state_d = ST_IDLE;
        end
      end
      ST_ON: begin
        if (!bothOn) begin
          state_d = ST_ERR; // RL2
          twoHandValid_d = 1'b0;
        end
      end
      ST_ERR: begin
        twoHandValid_d = 1'b0;
        if (bothOff) begin
          state_d = ST_IDLE; // RL2 RL10
          evalError_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_ERR;
        twoHandValid_d = 1'b0;
      end
    endcase
  end

  // ==========================================
  // State registers.
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_ERR;
      syncCnt_q <= 28'h0;
      twoHandValid_q <= 1'b0;
      evalError_q <= 1'b0;
    end else begin
      state_q <= state_d;
      syncCnt_q <= syncCnt_d;
      twoHandValid_q <= twoHandValid_d;
      evalError_q <= evalError_d;
    end
  end

  // ==========================================
  // Selector mode count check.
  wire [3:0] selectorMax = selectorTested ? `THSIE_MODES_MAX_TESTED : `THSIE_MODES_MAX_UNTESTED; // RL7
  wire selectorCfgOk_d = (selectorModes >= `THSIE_MODES_MIN) && (selectorModes <= selectorMax); // RL7
  always @(posedge mclk) begin
    if (sys_rst) begin
      selectorCfgOk_q <= 1'b0;
    end else begin
      selectorCfgOk_q <= selectorCfgOk_d; // RL7
    end
  end
endmodule // thsie_two_hand_eval
`default_nettype wire

// file: test/thsie_two_hand_eval_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checks on the two-hand outputs.
module thsie_two_hand_eval_properties (
  input wire logic mclk, sys_rst, complementaryMode, magneticMode, safe_input_one, safe_input_two,
  input wire logic safeInputThree, safeInputFour, selectorTested, twoHandValid_q, evalError_q, selectorCfgOk_q,
  input wire logic [8:0] pairDiscMs,
  input wire logic [3:0] selectorModes);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire eq = !complementaryMode;
  wire both = safe_input_one & safe_input_two;
  wire [3:0] pins = {safe_input_one, safe_input_two, safeInputThree, safeInputFour};
  chk_valid_both_on: assert property (twoHandValid_q && eq |-> $past(both, 3)) else $error("valid early");
  chk_valid_stands: assert property (twoHandValid_q && eq && $past(both, 2) |=> twoHandValid_q) else $error("drop");
  chk_valid_pairs_on: assert property (twoHandValid_q && !eq |-> $past(pins, 3) == 4'ha) else $error("pairs");
  chk_no_quick_rerise: assert property ($fell(twoHandValid_q) |=> !twoHandValid_q) else $error("rerise");
  chk_error_blocks_valid: assert property (evalError_q |-> !twoHandValid_q) else $error("valid in error");
  chk_error_holds: assert property (evalError_q && eq && $past(pins[3] | pins[2], 2) |=> evalError_q) else $error("err");
  chk_error_after_alone: assert property ($rose(evalError_q) && eq |-> $past(^pins[3:2], 20)) else $error("early");
  chk_selector_modes: assert property ($past(!sys_rst) |-> selectorCfgOk_q == ($past(selectorModes) >= 4'h2 &&
    $past(selectorModes) <= ($past(selectorTested) ? 4'h4 : 4'h8))) else $error("selector");
  cover property ($rose(twoHandValid_q));
  cover property ($rose(evalError_q));
  cover property ($rose(selectorCfgOk_q));
endmodule // thsie_two_hand_eval_properties
bind thsie_two_hand_eval thsie_two_hand_eval_properties chk (.*);
`default_nettype wire

// file: test/thsie_hand_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Two pushbuttons; in complementary use each has an open and a closed contact.
module thsie_hand_model (
  input wire logic complementary, handA, handB, ncStuck,
  output logic pinOne, pinTwo, pinThree, pinFour);
  assign pinOne = handA;
  assign pinTwo = complementary ? ~handA | ncStuck : handB;
  assign pinThree = handB;
  assign pinFour = ~handB;
  // Contacts sit at 24 V, so no test pulse pairing or test period applies.
endmodule // thsie_hand_model
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Stimulus and checks.
module testbench;
  logic mclk = 0, sys_rst = 1, comp = 0, mag = 0, stuck = 0, tst = 0;
  logic [1:0] hand = 2'h0;
  logic [8:0] disc = 9'h005;
  logic [3:0] modes = 4'h2;
  wire p1, p2, p3, p4, valid, err, ok;
  int mismatches = 0, compares = 0, cyc = 0;
  thsie_hand_model hands (.complementary(comp), .handA(hand[1]), .handB(hand[0]), .ncStuck(stuck),
    .pinOne(p1), .pinTwo(p2), .pinThree(p3), .pinFour(p4));
  thsie_two_hand_eval #(.SYNC_CYC(28'h64), .MAG_DISC_CYC(28'h12c), .CYC_PER_MS(28'ha)) uut (.mclk(mclk),
    .sys_rst(sys_rst), .complementaryMode(comp), .magneticMode(mag), .pairDiscMs(disc), .safe_input_one(p1),
    .safe_input_two(p2), .safeInputThree(p3), .safeInputFour(p4), .selectorTested(tst), .selectorModes(modes),
    .twoHandValid_q(valid), .evalError_q(err), .selectorCfgOk_q(ok));
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 5000) begin mismatches++; conclude; end
  task chk(input logic [1:0] g, e);
    compares++;
    if (g !== e) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
  endtask
  task run(input logic [1:0] h, input int n, input logic [1:0] ve);
    hand = h;
    repeat (n) @(posedge mclk);
    #1 chk({valid, err}, ve);
  endtask
  task conclude;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    run(2'h0, 5, 2'h0);
    run(2'h2, 90, 2'h0); run(2'h3, 5, 2'h2);
    run(2'h2, 5, 2'h0); run(2'h3, 5, 2'h0);
    run(2'h0, 5, 2'h0); run(2'h2, 110, 2'h1);
    run(2'h3, 5, 2'h1); run(2'h0, 5, 2'h0);
    mag = 1;
    run(2'h1, 200, 2'h0); run(2'h3, 5, 2'h2);
    run(2'h0, 5, 2'h0); run(2'h2, 310, 2'h1);
    run(2'h0, 5, 2'h0); mag = 0; comp = 1;
    run(2'h1, 90, 2'h0); run(2'h3, 5, 2'h2);
    run(2'h0, 5, 2'h0); stuck = 1;
    run(2'h2, 30, 2'h0); run(2'h2, 30, 2'h1);
    stuck = 0; run(2'h0, 5, 2'h0);
    disc = 9'h000; stuck = 1; run(2'h2, 5, 2'h1);
    stuck = 0; run(2'h0, 5, 2'h0);
    for (int i = 0; i < 32; i++) begin
      {tst, modes} = i[4:0];
      repeat (2) @(posedge mclk);
      #1 chk({1'h0, ok}, {1'h0, modes >= 4'h2 && modes <= (tst ? 4'h4 : 4'h8)});
    end
    conclude;
  end
endmodule // testbench
`default_nettype wire
